// ---- inc/icas_pkg.sv ----
// package for the input clock alarm status block
package icas_pkg;
    // register byte addresses
    localparam logic [7:0] ICAS_ADDR_TIMEOUT = 8'h08;
    localparam logic [7:0] ICAS_ADDR_MONCTL = 8'h09;
    localparam logic [7:0] ICAS_ADDR_STS34 = 8'h44;
    localparam logic [7:0] ICAS_ADDR_IRQ_STS = 8'h60;
    localparam logic [7:0] ICAS_ADDR_IRQ_CLR = 8'h61;
    localparam logic [7:0] ICAS_ADDR_IRQ_EN = 8'h62;
    // field positions
    localparam int ICAS_AUTOCLR_EN_BIT = 5;
    localparam int ICAS_TOVAL_LSB = 0;
    localparam int ICAS_TOVAL_W = 6;
    localparam int ICAS_MULT_LSB = 6;
    localparam int ICAS_MULT_W = 2;
    localparam int ICAS_FREQ_BIT = 2;
    localparam int ICAS_NOACT_BIT = 1;
    localparam int ICAS_PHASE_BIT = 0;
    localparam int ICAS_INPUT_STRIDE = 4;
    localparam int ICAS_NUM_INPUTS = 2;
    // reset values
    localparam logic [7:0] ICAS_TIMEOUT_RESET = 8'h00;
    localparam logic [7:0] ICAS_MONCTL_RESET = 8'h00;
    localparam logic [7:0] ICAS_IRQ_EN_RESET = 8'h00;
    localparam logic ICAS_NOACT_RESET = 1'b1;
    localparam logic ICAS_FREQ_RESET = 1'b1;
    localparam logic ICAS_PHASE_RESET = 1'b0;
    // timing: one second at 50 MHz
    localparam int ICAS_CLK_HZ = 50000000;
    localparam int ICAS_SECOND_S = 1;
    localparam int ICAS_SECOND_CYCLES = ICAS_CLK_HZ * ICAS_SECOND_S;
    // one input's alarm levels from the detectors
    typedef struct packed {
        logic freq_hard;
        logic no_activity;
        logic phase_lock;
    } icas_alarm_type;
    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } icas_bus_type;
endpackage : icas_pkg

// ---- rtl/icas_phase_timer.sv ----
// per-input phase-lock alarm latch with timed automatic clear
`timescale 1ns/1ps
module icas_phase_timer
    import icas_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic second_tick,
    input wire logic raise,
    input wire logic sw_clear,
    input wire logic autoclr_en,
    input wire logic [7:0] limit_seconds,
    // state
    output logic alarm
);
    logic [7:0] elapsed;

    // alarm latch: raise wins over clears
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alarm <= ICAS_PHASE_RESET;
        end else if (raise) begin
            alarm <= 1'b1;
        end else if (!autoclr_en && sw_clear) begin
            alarm <= 1'b0;
        end else if (autoclr_en && alarm && elapsed >= limit_seconds) begin
            alarm <= 1'b0;
        end
    end

    // seconds elapsed since the alarm was raised
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            elapsed <= 8'h00;
        end else if (raise && !alarm) begin
            elapsed <= 8'h00;
        end else if (alarm && second_tick && elapsed != 8'hFF) begin
            elapsed <= elapsed + 8'h01;
        end
    end
endmodule : icas_phase_timer

// ---- rtl/icas_status.sv ----
// input clock 3/4 alarm status register bank
//
// Function
// - each input shows a no-activity alarm bit, one while alarmed, resets to one.
// - each input shows a frequency hard alarm bit, one while alarmed, resets one.
// - each input shows a phase-lock alarm bit, set on alarm, resets to zero.
// - with auto-clear disabled, phase-lock alarm clears only by software writing one.
// - with auto-clear enabled, phase alarm clears after value times multiplier seconds.
// - status register 44H holds input 3 in bits 2..0, input 4 in 6..4.
`timescale 1ns/1ps
module icas_status
    import icas_pkg::*;
#(
    parameter int SECOND_CYCLES = ICAS_SECOND_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // alarm detector levels, asynchronous to clk
    input wire icas_alarm_type [ICAS_NUM_INPUTS-1:0] alarm_in,
    // interrupt
    output logic irq
);
    icas_bus_type bus;
    icas_alarm_type [ICAS_NUM_INPUTS-1:0] sync1;
    icas_alarm_type [ICAS_NUM_INPUTS-1:0] sync2;
    icas_alarm_type [ICAS_NUM_INPUTS-1:0] prev;
    logic [ICAS_NUM_INPUTS-1:0] noact;
    logic [ICAS_NUM_INPUTS-1:0] freq;
    logic [ICAS_NUM_INPUTS-1:0] phase;
    logic [7:0] timeout_reg;
    logic [7:0] monctl_reg;
    logic [7:0] irq_sts;
    logic [7:0] irq_en;
    logic [7:0] next_irq_sts;
    logic [7:0] sts34;
    logic [31:0] sec_cnt;
    logic second_tick;
    logic [7:0] limit_seconds;

    // detector levels assumed at reset: level alarms set, phase alarm clear
    localparam icas_alarm_type ALARM_RESET = '{
        freq_hard: ICAS_FREQ_RESET,
        no_activity: ICAS_NOACT_RESET,
        phase_lock: ICAS_PHASE_RESET
    };

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // write decode helper
    function automatic logic wr_hit(input icas_bus_type b, input logic [7:0] a);
        return b.wr && (b.addr == a);
    endfunction : wr_hit

    // two-stage synchroniser for detector levels; resets to the alarm reset
    // levels so the status bits hold their reset value and no false edge follows
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= {ICAS_NUM_INPUTS{ALARM_RESET}};
            sync2 <= {ICAS_NUM_INPUTS{ALARM_RESET}};
            prev <= {ICAS_NUM_INPUTS{ALARM_RESET}};
        end else begin
            sync1 <= alarm_in;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timeout_reg <= ICAS_TIMEOUT_RESET;
            monctl_reg <= ICAS_MONCTL_RESET;
            irq_en <= ICAS_IRQ_EN_RESET;
        end else begin
            if (wr_hit(bus, ICAS_ADDR_TIMEOUT)) timeout_reg <= bus.wdata;
            if (wr_hit(bus, ICAS_ADDR_MONCTL)) monctl_reg <= bus.wdata;
            if (wr_hit(bus, ICAS_ADDR_IRQ_EN)) irq_en <= bus.wdata;
        end
    end

    // one-second enable pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sec_cnt <= 32'h0;
            second_tick <= 1'b0;
        end else if (sec_cnt == 32'(SECOND_CYCLES - 1)) begin
            sec_cnt <= 32'h0;
            second_tick <= 1'b1;
        end else begin
            sec_cnt <= sec_cnt + 32'h1;
            second_tick <= 1'b0;
        end
    end

    // delay is value times multiplier in seconds
    // both factors widened first so the product keeps all eight bits
    assign limit_seconds = 8'(timeout_reg[ICAS_TOVAL_LSB +: ICAS_TOVAL_W])
        * 8'(timeout_reg[ICAS_MULT_LSB +: ICAS_MULT_W]);

    genvar gi;
    generate
        for (gi = 0; gi < ICAS_NUM_INPUTS; gi++) begin : g_in
            // level bits follow detectors, reset to one
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    noact[gi] <= ICAS_NOACT_RESET;
                    freq[gi] <= ICAS_FREQ_RESET;
                end else begin
                    noact[gi] <= sync2[gi].no_activity;
                    freq[gi] <= sync2[gi].freq_hard;
                end
            end

            // phase latch, cleared by write-one when auto-clear off
            icas_phase_timer u_phase (
                .clk(clk),
                .rst(rst),
                .second_tick(second_tick),
                .raise(sync2[gi].phase_lock && !prev[gi].phase_lock),
                .sw_clear(wr_hit(bus, ICAS_ADDR_STS34)
                    && bus.wdata[gi*ICAS_INPUT_STRIDE + ICAS_PHASE_BIT]),
                .autoclr_en(monctl_reg[ICAS_AUTOCLR_EN_BIT]),
                .limit_seconds(limit_seconds),
                .alarm(phase[gi])
            );
        end
    endgenerate

    // status layout with reserved bits zero
    always_comb begin
        sts34 = 8'h00;
        for (int i = 0; i < ICAS_NUM_INPUTS; i++) begin
            sts34[i*ICAS_INPUT_STRIDE + ICAS_FREQ_BIT] = freq[i];
            sts34[i*ICAS_INPUT_STRIDE + ICAS_NOACT_BIT] = noact[i];
            sts34[i*ICAS_INPUT_STRIDE + ICAS_PHASE_BIT] = phase[i];
        end
    end

    // interrupt events: rising alarm bits; set wins over clear
    always_comb begin
        next_irq_sts = irq_sts;
        if (wr_hit(bus, ICAS_ADDR_IRQ_CLR)) next_irq_sts = irq_sts & ~bus.wdata;
        for (int i = 0; i < ICAS_NUM_INPUTS; i++) begin
            if (sync2[i].freq_hard && !prev[i].freq_hard)
                next_irq_sts[i*ICAS_INPUT_STRIDE + ICAS_FREQ_BIT] = 1'b1;
            if (sync2[i].no_activity && !prev[i].no_activity)
                next_irq_sts[i*ICAS_INPUT_STRIDE + ICAS_NOACT_BIT] = 1'b1;
            if (sync2[i].phase_lock && !prev[i].phase_lock)
                next_irq_sts[i*ICAS_INPUT_STRIDE + ICAS_PHASE_BIT] = 1'b1;
        end
    end

    // interrupt status and output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_sts <= 8'h00;
            irq <= 1'b0;
        end else begin
            irq_sts <= next_irq_sts;
            irq <= |(next_irq_sts & irq_en);
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                ICAS_ADDR_TIMEOUT: rdata <= timeout_reg;
                ICAS_ADDR_MONCTL: rdata <= monctl_reg;
                ICAS_ADDR_STS34: rdata <= sts34;
                ICAS_ADDR_IRQ_STS: rdata <= irq_sts;
                ICAS_ADDR_IRQ_EN: rdata <= irq_en;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule : icas_status

// ---- tb/icas_status_assertions.sv ----
// checker for the alarm status bank
`timescale 1ns/1ps
module icas_status_chk
    import icas_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port and alarms
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire icas_alarm_type [ICAS_NUM_INPUTS-1:0] alarm_in,
    // interrupt
    input wire logic irq
);
    logic [1:0] n;
    logic [7:0] ie;
    logic rdq, rq, ae, pv, p, rs, stab;
    icas_alarm_type [1:0] a1, a2, a3;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // status read now; inputs steady over four samples
    assign rs = rd && addr == 8'h44;
    assign stab = n == 2'h3 && alarm_in == a1 && a1 == a2 && a2 == a3;
    // cycles since reset and read history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            n <= 2'h0;
            rdq <= 1'b0;
            rq <= 1'b0;
        end else begin
            n <= n + {1'b0, n != 2'h3};
            rdq <= rd;
            rq <= rs;
        end
    end
    // detector history
    always_ff @(posedge clk) begin
        a1 <= alarm_in;
        a2 <= a1;
        a3 <= a2;
    end
    // auto-clear enable and last input 3 phase bit seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ae <= 1'b0;
            pv <= 1'b0;
            p <= 1'b0;
        end else if (wr && (addr == 8'h09 || addr == 8'h44 && wdata[0])) begin
            ae <= addr == 8'h09 ? wdata[5] : ae;
            pv <= 1'b0;
        end else if (rq) begin
            pv <= 1'b1;
            p <= rdata[0];
        end
    end
    // interrupt enable as last written
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ie <= 8'h00;
        end else if (wr && addr == ICAS_ADDR_IRQ_EN) begin
            ie <= wdata;
        end
    end
    a_irq_masked: assert property (ie == 8'h00 |=> !irq) // interrupt enable
        else $error("interrupt high while all sources masked");
    a_rdata_idle: assert property (!rdq |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_reserved_zero: assert property (rq |-> !rdata[7] && !rdata[3])
        else $error("reserved status bit set");
    a_reset_read: assert property (rs && n == 2'h1 |=> rdata == 8'h66)
        else $error("status not at reset value");
    a_level_bits: assert property (rs && stab |=> {rdata[6:5], rdata[2:1]} ==
        {a1[1].freq_hard, a1[1].no_activity, a1[0].freq_hard, a1[0].no_activity})
        else $error("level bit differs from detector");
    a_phase_hold: assert property (rq && pv && p && !ae |-> rdata[0])
        else $error("phase bit cleared without write");
    c_sts_read: cover property (rs && stab);
    c_phase_wr: cover property (wr && addr == 8'h44 && wdata[0]);
    c_autoclr: cover property (rq && ae && !rdata[4]);
endmodule : icas_status_chk

// ---- tb/tb.sv ----
// self-checking bench for the alarm status bank
`timescale 1ns/1ps
module tb;
    import icas_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, irq;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    icas_alarm_type [1:0] alarm_in = '0, v;
    int bad_count = 0, tests_run = 0, seed = 32'h98810AB9;
    icas_status #(.SECOND_CYCLES(10)) dut_u (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .alarm_in(alarm_in), .irq(irq));
    // 50 MHz clock
    initial forever #10 clk = ~clk;
    // expected status byte
    function automatic logic [7:0] sts(icas_alarm_type [1:0] a, logic [1:0] ph);
        return {1'b0, a[1], 1'b0, a[0]} & 8'h66 | {3'h0, ph[1], 3'h0, ph[0]};
    endfunction : sts
    // compare and bus tasks
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(e, rdata);
    endtask : rchk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h44, 8'h66);
        for (int i = 0; i < 8; i++) begin
            v = i == 0 ? 6'h00 : i == 1 ? 6'h36 : 6'($random(seed)) & 6'h36;
            @(posedge clk) alarm_in <= v;
            repeat (4) @(posedge clk);
            rchk(8'h44, sts(v, 2'b00));
        end
        $display("levels done");
        wreg(8'h62, 8'h77);
        wreg(8'h61, 8'hFF);
        repeat (2) @(posedge clk);
        #1 chk(8'h00, {7'h00, irq});
        v[0].phase_lock = 1'b1;
        @(posedge clk) alarm_in <= v;
        repeat (6) @(posedge clk);
        #1 chk(8'h01, {7'h00, irq});
        rchk(8'h60, 8'h01);
        rchk(8'h44, sts(v, 2'b01));
        wreg(8'h44, 8'hEE);
        rchk(8'h44, sts(v, 2'b01));
        wreg(8'h44, 8'h01);
        rchk(8'h44, sts(v, 2'b00));
        rchk(8'h50, 8'h00);
        wreg(8'h62, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk(8'h00, {7'h00, irq});
        $display("phase done");
        v[0].phase_lock = 1'b0;
        wreg(8'h09, 8'h20);
        wreg(8'h08, 8'h42);
        v[1].phase_lock = 1'b1;
        @(posedge clk) alarm_in <= v;
        repeat (3) @(posedge clk);
        wreg(8'h44, 8'h10);
        rchk(8'h44, sts(v, 2'b10));
        repeat (5) @(posedge clk);
        rchk(8'h44, sts(v, 2'b10));
        repeat (30) @(posedge clk);
        rchk(8'h44, sts(v, 2'b00));
        $display("auto-clear done");
        tally_and_finish();
    end
    // watchdog
    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end
endmodule : tb
bind icas_status icas_status_chk chk_u (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .alarm_in(alarm_in), .irq(irq));
